// ===== src/cop_pkg.sv
package cop_pkg;

    localparam int           NUM_PAIRS_DEF = 6;
    localparam int           DRV_W         = 7;

    localparam logic [7:0]   A_PAIR_EN     = 8'h00;
    localparam logic [7:0]   A_POLARITY    = 8'h04;
    localparam logic [7:0]   A_CONFIG_BYTE_THREE       = 8'h08;
    localparam logic [7:0]   A_SPREAD      = 8'h0c;
    localparam logic [7:0]   A_DIS_LVL     = 8'h10;
    localparam logic [7:0]   A_DRV_BASE    = 8'h14;
    localparam logic [7:0]   A_STATUS      = 8'h40;

    localparam logic [7:0]   RST_PAIR_EN   = 8'hff;
    localparam logic [7:0]   RST_POLARITY  = 8'h00;
    localparam logic [7:0]   RST_CONFIG_BYTE_THREE     = 8'h10;
    localparam logic [2:0]   RST_SPREAD    = 3'h0;
    localparam logic [1:0]   RST_DIS_LVL   = 2'h0;

    localparam int           B3_REF_EN     = 4;
    localparam int           B3_REF_PD_RUN = 5;
    localparam int           SPR_OVR_BIT   = 2;

    localparam int           ST_ADDR_LSB   = 0;
    localparam int           ST_SPR_LSB    = 7;
    localparam int           ST_PG         = 9;
    localparam int           ST_LOCK       = 10;
    localparam int           ST_UP         = 11;
    localparam int           ST_REF        = 12;
    localparam int           ST_PAIR_LSB   = 16;

    localparam logic [6:0]   ADDR_STRAP0   = 7'h68;
    localparam logic [6:0]   ADDR_STRAP1   = 7'h6a;

    localparam logic [1:0]   STRAP_LOW     = 2'h0;
    localparam logic [1:0]   STRAP_MID     = 2'h1;

    localparam logic [1:0]   IMP_33        = 2'h0;
    localparam logic [1:0]   IMP_85        = 2'h1;
    localparam logic [1:0]   IMP_100       = 2'h2;

    typedef enum logic [1:0] {
        SPR_OFF = 2'b00,
        SPR_025 = 2'b01,
        SPR_050 = 2'b10
    } cop_spread_t;

    typedef enum logic [1:0] {
        UP_WAIT  = 2'b00,
        UP_RUN   = 2'b01,
        UP_SLEEP = 2'b10
    } cop_up_t;

    typedef struct packed {
        logic [1:0] amp;
        logic       pull;
        logic [1:0] imp;
        logic [1:0] slew;
    } cop_drv_t;

    typedef struct packed {
        logic tru;
        logic cmp;
    } cop_pair_t;

    localparam cop_drv_t     RST_DRV       = '{amp: 2'h2, pull: 1'h1, imp: IMP_100, slew: 2'h3};

endpackage : cop_pkg

// ===== src/cop_top.sv
`timescale 1ns/1ns
// How it works
// - Address strap at first power-good picks slave address 1101000 or 1101010.
// - Pair runs with power-good high, enable bit set and pin at active level.
// - Disabled or powered-down pairs drive the two-bit disabled level field.
// - Crystal copy stays high impedance until power-good first goes high.
// - Later power-good low disables crystal copy unless byte three bit 5.
// - With power-good high the crystal copy follows byte three bit 4.
// - All pairs stay blocked until the synthesizer reports lock.
// - Spread is off, -0.25% or -0.5%, from strap or software.
// - Six independent pair enables, one per pair.
// - Per output slew, impedance, amplitude and pull settings are held.
// - Reset defaults run every output without any bus access.
// - First power-good high samples straps; low sleeps, high again wakes.
// - Three-level spread strap: high -0.5%, mid -0.25%, low off.
// - Pair enable pins are active low by default.
module cop_top #(
    parameter int NUM_PAIRS = cop_pkg::NUM_PAIRS_DEF
) (
    input  wire logic                                sys_clk,
    input  wire logic                                srst,
    input  wire logic                                out_clk,
    input  wire logic [7:0]                          avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [31:0]                         avs_writedata,
    output      logic [31:0]                         avs_readdata,
    output      logic                                avs_waitrequest,
    input  wire logic                                power_good_sleep_n,
    input  wire logic                                pll_lock,
    input  wire logic [1:0]                          spread_strap,
    input  wire logic [NUM_PAIRS-1:0]                pair_enable_n_pin,
    input  wire logic                                slave_addr_strap,
    output      logic                                ref_out,
    output      logic                                ref_oe,
    output      cop_pkg::cop_pair_t [NUM_PAIRS-1:0]  diff_clock_pair,
    output      logic [6:0]                          smbus_addr,
    output      cop_pkg::cop_spread_t                spread_active,
    output      cop_pkg::cop_drv_t [NUM_PAIRS:0]     drive_cfg
);

    generate
        if (NUM_PAIRS < 1 || NUM_PAIRS > 8) begin : g_bad
            $error("NUM_PAIRS must be 1 to 8");
        end
    endgenerate

    function automatic cop_pkg::cop_spread_t strap_to_spread(input logic [1:0] s);
        if (s == cop_pkg::STRAP_LOW) begin
            return cop_pkg::SPR_OFF;
        end else if (s == cop_pkg::STRAP_MID) begin
            return cop_pkg::SPR_025;
        end
        return cop_pkg::SPR_050;
    endfunction : strap_to_spread

    // Input synchronisers, system domain
    logic                       pg_m, pg_s;
    logic                       lock_m, lock_s;
    logic                       adr_m, adr_s;
    logic [1:0]                 spr_m, spr_s;
    logic [NUM_PAIRS-1:0]       pin_m, pin_s;
    logic [NUM_PAIRS-1:0]       gate_m, gate_s;
    logic                       rrun_back_m, rrun_back_s;

    // Software state
    logic [NUM_PAIRS-1:0]       pair_en_q;
    logic [NUM_PAIRS-1:0]       polarity_q;
    logic [7:0]                 config_byte_three_q;
    logic [2:0]                 spread_cfg_q;
    logic [1:0]                 dis_lvl_q;
    cop_pkg::cop_drv_t [NUM_PAIRS:0] drv_q;

    // Device state
    cop_pkg::cop_up_t           up_q;
    logic [6:0]                 addr_q;
    cop_pkg::cop_spread_t       strap_spr_q;
    cop_pkg::cop_spread_t       spread_q;
    logic [NUM_PAIRS-1:0]       pair_run_q;
    logic                       ref_oe_lvl_q;
    logic                       ref_run_lvl_q;

    // Bus slave
    logic                       wait_q;
    logic [31:0]                rdata_q;
    logic [31:0]                rd_word;
    logic                       wr_fire;

    // Output clock domain, with its reset request and acknowledge in the system domain
    logic                       orst_req_q, orst_ack_m, orst_ack_s;
    logic                       orst_m, orst_q;
    logic [NUM_PAIRS-1:0]       run_m, run_s;
    logic [1:0]                 lvl_m, lvl_s;
    logic                       rrun_m, rrun_s;
    logic                       phase_q;
    logic [NUM_PAIRS-1:0]       gate_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pg_m        <= 1'b0;
            pg_s        <= 1'b0;
            lock_m      <= 1'b0;
            lock_s      <= 1'b0;
            adr_m       <= 1'b0;
            adr_s       <= 1'b0;
            spr_m       <= 2'h0;
            spr_s       <= 2'h0;
            pin_m       <= '0;
            pin_s       <= '0;
            gate_m      <= '0;
            gate_s      <= '0;
            rrun_back_m <= 1'b0;
            rrun_back_s <= 1'b0;
            orst_ack_m  <= 1'b0;
            orst_ack_s  <= 1'b0;
        end else begin
            pg_m        <= power_good_sleep_n;
            pg_s        <= pg_m;
            lock_m      <= pll_lock;
            lock_s      <= lock_m;
            adr_m       <= slave_addr_strap;
            adr_s       <= adr_m;
            spr_m       <= spread_strap;
            spr_s       <= spr_m;
            pin_m       <= pair_enable_n_pin;
            pin_s       <= pin_m;
            gate_m      <= gate_q;
            gate_s      <= gate_m;
            rrun_back_m <= rrun_s;
            rrun_back_s <= rrun_back_m;
            orst_ack_m  <= orst_q;
            orst_ack_s  <= orst_ack_m;
        end
    end

    // Straps are read only before the shared pin turns into the crystal copy output
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            up_q        <= cop_pkg::UP_WAIT;
            addr_q      <= cop_pkg::ADDR_STRAP0;
            strap_spr_q <= cop_pkg::SPR_OFF;
        end else begin
            case (up_q)
                cop_pkg::UP_WAIT: begin
                    if (pg_s) begin
                        up_q        <= cop_pkg::UP_RUN;
                        addr_q      <= adr_s ? cop_pkg::ADDR_STRAP1
                                             : cop_pkg::ADDR_STRAP0;
                        strap_spr_q <= strap_to_spread(spr_s);
                    end
                end
                cop_pkg::UP_RUN: begin
                    if (!pg_s) begin
                        up_q <= cop_pkg::UP_SLEEP;
                    end
                end
                cop_pkg::UP_SLEEP: begin
                    if (pg_s) begin
                        up_q <= cop_pkg::UP_RUN;
                    end
                end
                default: begin
                    up_q <= cop_pkg::UP_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            spread_q <= cop_pkg::SPR_OFF;
        end else if (spread_cfg_q[cop_pkg::SPR_OVR_BIT]) begin
            spread_q <= cop_pkg::cop_spread_t'(spread_cfg_q[1:0]);
        end else begin
            spread_q <= strap_spr_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pair_run_q <= '0;
        end else begin
            for (int i = 0; i < NUM_PAIRS; i++) begin
                pair_run_q[i] <= (up_q == cop_pkg::UP_RUN) && lock_s
                              && pair_en_q[i]
                              && !(pin_s[i] ^ polarity_q[i]);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ref_oe_lvl_q  <= 1'b0;
            ref_run_lvl_q <= 1'b0;
        end else begin
            ref_oe_lvl_q <= (up_q != cop_pkg::UP_WAIT);
            case (up_q)
                cop_pkg::UP_RUN:   ref_run_lvl_q <= config_byte_three_q[cop_pkg::B3_REF_EN];
                cop_pkg::UP_SLEEP: ref_run_lvl_q <= config_byte_three_q[cop_pkg::B3_REF_PD_RUN];
                default:           ref_run_lvl_q <= 1'b0;
            endcase
        end
    end

    // Every transfer costs two cycles; waitrequest idles high
    assign wr_fire = avs_write && !wait_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
            if (avs_read && wait_q) begin
                rdata_q <= rd_word;
            end
        end
    end

    always_comb begin
        rd_word = 32'h0;
        case (avs_address)
            cop_pkg::A_PAIR_EN:  rd_word[NUM_PAIRS-1:0] = pair_en_q;
            cop_pkg::A_POLARITY: rd_word[NUM_PAIRS-1:0] = polarity_q;
            cop_pkg::A_CONFIG_BYTE_THREE:    rd_word[7:0] = config_byte_three_q;
            cop_pkg::A_SPREAD:   rd_word[2:0] = spread_cfg_q;
            cop_pkg::A_DIS_LVL:  rd_word[1:0] = dis_lvl_q;
            cop_pkg::A_STATUS: begin
                rd_word[cop_pkg::ST_ADDR_LSB +: 7] = addr_q;
                rd_word[cop_pkg::ST_SPR_LSB +: 2]  = spread_q;
                rd_word[cop_pkg::ST_PG]            = pg_s;
                rd_word[cop_pkg::ST_LOCK]          = lock_s;
                rd_word[cop_pkg::ST_UP]            = (up_q == cop_pkg::UP_RUN);
                rd_word[cop_pkg::ST_REF]           = rrun_back_s;
                rd_word[cop_pkg::ST_PAIR_LSB +: NUM_PAIRS] = gate_s;
            end
            default: begin
                for (int i = 0; i <= NUM_PAIRS; i++) begin
                    if (avs_address == cop_pkg::A_DRV_BASE + 8'(4 * i)) begin
                        rd_word[cop_pkg::DRV_W-1:0] = drv_q[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pair_en_q    <= cop_pkg::RST_PAIR_EN[NUM_PAIRS-1:0];
            polarity_q   <= cop_pkg::RST_POLARITY[NUM_PAIRS-1:0];
            config_byte_three_q      <= cop_pkg::RST_CONFIG_BYTE_THREE;
            spread_cfg_q <= cop_pkg::RST_SPREAD;
            dis_lvl_q    <= cop_pkg::RST_DIS_LVL;
            for (int i = 0; i <= NUM_PAIRS; i++) begin
                drv_q[i] <= cop_pkg::RST_DRV;
            end
        end else if (wr_fire) begin
            case (avs_address)
                cop_pkg::A_PAIR_EN:  pair_en_q    <= avs_writedata[NUM_PAIRS-1:0];
                cop_pkg::A_POLARITY: polarity_q   <= avs_writedata[NUM_PAIRS-1:0];
                cop_pkg::A_CONFIG_BYTE_THREE:    config_byte_three_q      <= avs_writedata[7:0];
                cop_pkg::A_SPREAD:   spread_cfg_q <= avs_writedata[2:0];
                cop_pkg::A_DIS_LVL:  dis_lvl_q    <= avs_writedata[1:0];
                default: begin
                    for (int i = 0; i <= NUM_PAIRS; i++) begin
                        if (avs_address == cop_pkg::A_DRV_BASE + 8'(4 * i)) begin
                            drv_q[i] <= avs_writedata[cop_pkg::DRV_W-1:0];
                        end
                    end
                end
            endcase
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;
    assign smbus_addr      = addr_q;
    assign spread_active   = spread_q;
    assign drive_cfg       = drv_q;
    assign ref_oe          = ref_oe_lvl_q;

    // The output domain may run far slower, so its reset is held until it answers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            orst_req_q <= 1'b1;
        end else if (orst_ack_s) begin
            orst_req_q <= 1'b0;
        end
    end

    always_ff @(posedge out_clk) begin
        orst_m <= orst_req_q;
        orst_q <= orst_m;
        run_m  <= pair_run_q;
        run_s  <= run_m;
        lvl_m  <= dis_lvl_q;
        lvl_s  <= lvl_m;
        rrun_m <= ref_run_lvl_q;
        rrun_s <= rrun_m;
    end

    // Gates move only at the end of a high phase, so no high phase is cut short
    always_ff @(posedge out_clk) begin
        if (orst_q) begin
            phase_q <= 1'b0;
            gate_q  <= '0;
        end else begin
            phase_q <= ~phase_q;
            if (phase_q) begin
                gate_q <= run_s;
            end
        end
    end

    always_ff @(posedge out_clk) begin
        ref_out <= rrun_s && phase_q;
        for (int i = 0; i < NUM_PAIRS; i++) begin
            diff_clock_pair[i].tru <= gate_q[i] ? phase_q : lvl_s[1];
            diff_clock_pair[i].cmp <= gate_q[i] ? !phase_q : lvl_s[0];
        end
    end

endmodule : cop_top

// ===== sim/cop_top_props.sv
`timescale 1ns/1ns
module cop_top_props #(
    parameter int NUM_PAIRS = 6
) (
    input wire logic                               sys_clk,
    input wire logic                               srst,
    input wire logic                               avs_read,
    input wire logic                               avs_write,
    input wire logic                               avs_waitrequest,
    input wire logic                               power_good_sleep_n,
    input wire logic                               pll_lock,
    input wire logic [NUM_PAIRS-1:0]               pair_enable_n_pin,
    input wire logic                               slave_addr_strap,
    input wire logic                               ref_oe,
    input wire cop_pkg::cop_pair_t [NUM_PAIRS-1:0] diff_clock_pair,
    input wire logic [6:0]                         smbus_addr,
    input wire cop_pkg::cop_drv_t [NUM_PAIRS:0]    drive_cfg
);
    logic       seen_q;
    logic       cap_q;
    logic [8:0] up_q;
    logic [8:0] lo_q;
    logic [8:0] pin_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seen_q <= 1'h0;
            cap_q  <= 1'h0;
        end else if (power_good_sleep_n && !seen_q) begin
            seen_q <= 1'h1;
            cap_q  <= slave_addr_strap;
        end
    end
    // Saturating; lo_q and pin_q are also cleared by writes, since a write may move the parked level
    always_ff @(posedge sys_clk) begin
        up_q  <= (srst || !seen_q) ? 9'h0 : up_q + {8'h0, ~&up_q};
        lo_q  <= (srst || avs_write || (power_good_sleep_n && pll_lock)) ? 9'h0
                                                          : lo_q + {8'h0, ~&lo_q};
        pin_q <= (srst || avs_write || !pair_enable_n_pin[0]) ? 9'h0 : pin_q + {8'h0, ~&pin_q};
    end
    chk_ref_hiz_start : assert property (@(posedge sys_clk) disable iff (srst)
        !seen_q |-> !ref_oe) else $error("crystal copy driven too early");
    chk_addr_pick : assert property (@(posedge sys_clk) disable iff (srst)
        up_q > 9'h64 |-> smbus_addr == (cap_q ? cop_pkg::ADDR_STRAP1 : cop_pkg::ADDR_STRAP0))
        else $error("slave address does not match strap");
    chk_addr_hold : assert property (@(posedge sys_clk) disable iff (srst)
        up_q > 9'h64 |=> $stable(smbus_addr)) else $error("slave address moved");
    chk_nolock_quiet : assert property (@(posedge sys_clk) disable iff (srst)
        lo_q > 9'hfa && !pll_lock |-> $stable(diff_clock_pair)) else $error("edges before lock");
    chk_sleep_quiet : assert property (@(posedge sys_clk) disable iff (srst)
        lo_q > 9'hfa && !power_good_sleep_n |-> $stable(diff_clock_pair))
        else $error("edges in power down");
    chk_pin_quiet : assert property (@(posedge sys_clk) disable iff (srst)
        pin_q > 9'hfa |-> $stable(diff_clock_pair[0])) else $error("pair 0 runs with pin high");
    chk_bus_answer : assert property (@(posedge sys_clk) disable iff (srst)
        (avs_read || avs_write) |-> ##[0:32] !avs_waitrequest) else $error("bus never answers");
    chk_drv_default : assert property (@(posedge sys_clk) disable iff (srst)
        $past(srst) |-> drive_cfg == {(NUM_PAIRS+1){cop_pkg::RST_DRV}})
        else $error("drive settings not at default");
endmodule : cop_top_props

bind cop_top cop_top_props #(.NUM_PAIRS(NUM_PAIRS)) u_props (
    .sys_clk(sys_clk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .power_good_sleep_n(power_good_sleep_n),
    .pll_lock(pll_lock), .pair_enable_n_pin(pair_enable_n_pin),
    .slave_addr_strap(slave_addr_strap), .ref_oe(ref_oe), .diff_clock_pair(diff_clock_pair),
    .smbus_addr(smbus_addr), .drive_cfg(drive_cfg));

// ===== sim/cop_rx_model.sv
`timescale 1ns/1ns
module cop_rx_model #(
    parameter int NUM_PAIRS = 6
) (
    input wire logic                               clear,
    input wire cop_pkg::cop_pair_t [NUM_PAIRS-1:0] pairs,
    input wire logic                               ref_out,
    input wire logic                               ref_oe,
    output int                                     edges [NUM_PAIRS+1],
    output logic                                   runt
);
    // Listen only; a high phase under 40 ns means a gate cut a phase short
    initial runt = 1'h0;
    for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_rx
        realtime rise_t = -1000.0;
        always @(posedge pairs[i].tru or posedge clear) begin
            if (clear) edges[i] = 0;
            else begin
                edges[i] = edges[i] + 1;
                rise_t = $realtime;
            end
        end
        always @(negedge pairs[i].tru) begin
            if ($realtime - rise_t < 40.0) runt = 1'h1;
        end
    end
    always @(posedge ref_out or posedge clear) begin
        if (clear) edges[NUM_PAIRS] = 0;
        else if (ref_oe) edges[NUM_PAIRS] = edges[NUM_PAIRS] + 1;
    end
endmodule : cop_rx_model

// ===== sim/cop_top_bench.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module cop_top_bench;
    localparam int NP = 6;
    logic                        sys_clk = 1'h0;
    logic                        out_clk = 1'h0;
    logic                        srst = 1'h1;
    logic [7:0]                  avs_address = 8'h0;
    logic                        avs_read = 1'h0;
    logic                        avs_write = 1'h0;
    logic [31:0]                 avs_writedata = 32'h0;
    logic [31:0]                 avs_readdata;
    logic                        avs_waitrequest;
    logic                        pg = 1'h0;
    logic                        lock = 1'h0;
    logic [1:0]                  spr_strap = 2'h0;
    logic [NP-1:0]               pin_n = '0;
    logic                        adr_strap = 1'h0;
    logic                        ref_out;
    logic                        ref_oe;
    cop_pkg::cop_pair_t [NP-1:0] pairs;
    logic [6:0]                  smbus_addr;
    cop_pkg::cop_spread_t        spread_active;
    cop_pkg::cop_drv_t [NP:0]    drive_cfg;
    logic                        clear = 1'h0;
    int                          edges [NP+1];
    logic                        runt;
    int                          fail_count = 0;
    int                          checked = 0;
    cop_top #(.NUM_PAIRS(NP)) dut (
        .sys_clk(sys_clk), .srst(srst), .out_clk(out_clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .power_good_sleep_n(pg), .pll_lock(lock), .spread_strap(spr_strap),
        .pair_enable_n_pin(pin_n), .slave_addr_strap(adr_strap), .ref_out(ref_out),
        .ref_oe(ref_oe), .diff_clock_pair(pairs), .smbus_addr(smbus_addr),
        .spread_active(spread_active), .drive_cfg(drive_cfg));
    cop_rx_model #(.NUM_PAIRS(NP)) u_rx (.clear(clear), .pairs(pairs), .ref_out(ref_out),
        .ref_oe(ref_oe), .edges(edges), .runt(runt));
    initial forever #2 sys_clk = ~sys_clk;
    initial begin
        #1;
        forever begin
            #62 out_clk = 1'h1;
            #63 out_clk = 1'h0;
        end
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        #380000;
        fail_count++;
        wrap_up();
    end
    function automatic cop_pkg::cop_spread_t exp_spr(input logic [1:0] s);
        if (s == cop_pkg::STRAP_LOW) return cop_pkg::SPR_OFF;
        if (s == cop_pkg::STRAP_MID) return cop_pkg::SPR_025;
        return cop_pkg::SPR_050;
    endfunction : exp_spr
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 64);
        q = avs_readdata;
        avs_read  <= 1'h0;
        avs_write <= 1'h0;
        if (n >= 64) begin
            fail_count++;
            wrap_up();
        end
    endtask : bus
    task automatic window(input int n);
        repeat (300) @(posedge sys_clk);
        clear <= 1'h1;
        @(posedge sys_clk);
        clear <= 1'h0;
        repeat (n) @(posedge sys_clk);
    endtask : window
    task automatic bring_up(input logic [1:0] s, input logic a);
        srst      <= 1'h1;
        pg        <= 1'h0;
        lock      <= 1'h0;
        spr_strap <= s;
        adr_strap <= a;
        repeat (12) @(posedge sys_clk);
        srst <= 1'h0;
        repeat (100) @(posedge sys_clk);
        `CHK(ref_oe, 1'h0)
        pg <= 1'h1;
        window(300);
        `CHK(edges[0], 0)
        lock <= 1'h1;
        repeat (300) @(posedge sys_clk);
    endtask : bring_up
    initial begin
        logic [31:0] q;
        logic [6:0]  xa;
        logic [6:0]  dv;
        int          m;
        int          p;
        void'($urandom(32'h59e57dc8));
        for (int s = 0; s < 3; s++) begin
            xa = s[0] ? cop_pkg::ADDR_STRAP1 : cop_pkg::ADDR_STRAP0;
            bring_up(s[1:0], s[0]);
            adr_strap <= ~s[0];
            spr_strap <= ~s[1:0];
            bus(1'h0, cop_pkg::A_STATUS, 32'h0, q);
            `CHK(smbus_addr, xa)
            `CHK(q[6:0], xa)
            `CHK(spread_active, exp_spr(s[1:0]))
        end
        bus(1'h0, cop_pkg::A_PAIR_EN, 32'h0, q);
        `CHK(q[NP-1:0], {NP{1'h1}})
        bus(1'h0, cop_pkg::A_CONFIG_BYTE_THREE, 32'h0, q);
        `CHK(q[5:4], 2'h1)
        bus(1'h0, cop_pkg::A_DIS_LVL, 32'h0, q);
        `CHK(q[1:0], cop_pkg::RST_DIS_LVL)
        bus(1'h0, 8'hfc, 32'h0, q);
        for (int i = 0; i < 3; i++) begin
            m  = $urandom % (NP + 1);
            dv = {2'($urandom), 1'($urandom), 2'(i), 2'($urandom)};
            bus(1'h1, cop_pkg::A_DRV_BASE + 8'(4 * m), {25'h0, dv}, q);
            bus(1'h0, cop_pkg::A_DRV_BASE + 8'(4 * m), 32'h0, q);
            `CHK(q[6:0], dv)
            `CHK(drive_cfg[m], dv)
        end
        for (int k = 0; k < 4; k++) begin
            m = $urandom % 64;
            p = $urandom % 64;
            bus(1'h1, cop_pkg::A_PAIR_EN, 32'(m), q);
            pin_n <= p[NP-1:0];
            window(400);
            for (int i = 0; i < NP; i++) `CHK(edges[i] > 2, m[i] && !p[i])
        end
        pin_n <= '0;
        bus(1'h1, cop_pkg::A_DIS_LVL, 32'h2, q);
        pg <= 1'h0;
        window(400);
        for (int i = 0; i < NP; i++) `CHK(pairs[i], 2'h2)
        `CHK(edges[NP], 0)
        bus(1'h1, cop_pkg::A_CONFIG_BYTE_THREE, 32'h30, q);
        window(400);
        `CHK(edges[NP] > 2, 1'h1)
        pg <= 1'h1;
        bus(1'h1, cop_pkg::A_PAIR_EN, 32'h0, q);
        bus(1'h1, cop_pkg::A_CONFIG_BYTE_THREE, 32'h0, q);
        window(400);
        `CHK(edges[NP], 0)
        bus(1'h1, cop_pkg::A_CONFIG_BYTE_THREE, 32'h10, q);
        window(400);
        `CHK(edges[NP] > 2, 1'h1)
        for (int c = 0; c < 3; c++) begin
            bus(1'h1, cop_pkg::A_SPREAD, 32'(c) | 32'h4, q);
            repeat (10) @(posedge sys_clk);
            `CHK(spread_active, cop_pkg::cop_spread_t'(c))
        end
        `CHK(runt, 1'h0)
        wrap_up();
    end
endmodule : cop_top_bench
